/* nipc_defs.vh */
// Constants of the nested interrupt priority controller: register offsets,
// field positions, reset values, level codes and vector addresses.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef NIPC_DEFS_VH
`define NIPC_DEFS_VH

// Register byte offsets on the APB.
`define NIPC_OFS_PRIO_SET_0   8'h00
`define NIPC_OFS_PRIO_SET_1   8'h04
`define NIPC_OFS_PRIO_SET_2   8'h08
`define NIPC_OFS_PRIO_SET_3   8'h0c
`define NIPC_OFS_EXT_CTRL     8'h10
`define NIPC_OFS_STATUS       8'h14

// Reset values.
`define NIPC_PRIO_RESET       8'hff
`define NIPC_EXT_CTRL_RESET   8'h00

// Fields of ext_irq_control.
`define NIPC_SENS_PORTB_HI    7
`define NIPC_SENS_PORTB_LO    6
`define NIPC_POL_INV_B        5
`define NIPC_SENS_PORTAF_HI   4
`define NIPC_SENS_PORTAF_LO   3
`define NIPC_POL_INV_A        2
`define NIPC_EXT_CTRL_WMASK   8'hfc

// Read-only upper nibble of prio_set_3.
`define NIPC_PRIO3_RO_ONES    4'hf

// Current-level codes.
`define NIPC_LEVEL_0          2'b10
`define NIPC_LEVEL_1          2'b01
`define NIPC_LEVEL_2          2'b00
`define NIPC_LEVEL_3          2'b11

// Sensitivity codes.
`define NIPC_SENS_FALL_LOW    2'b00
`define NIPC_SENS_RISE        2'b01
`define NIPC_SENS_FALL        2'b10
`define NIPC_SENS_BOTH        2'b11

// Vector addresses.
`define NIPC_VEC_RESET        16'hfffe
`define NIPC_VEC_TRAP         16'hfffc
`define NIPC_VEC_PAIR0        16'hfffa

// Vector numbers of the sources.
`define NIPC_IDX_CLK_TB       4'd1
`define NIPC_IDX_EXT_A        4'd2
`define NIPC_IDX_EXT_D        4'd5
`define NIPC_IDX_SPI          4'd7

// Sources with a vector, sources that leave halt and active-halt.
`define NIPC_USED_MASK        14'h07be
`define NIPC_HALT_WAKE_MASK   14'h00be
`define NIPC_AHALT_WAKE_MASK  14'h0002

`endif

/* nipc_ext_sense.v */
// One external interrupt line: sensitivity decode, edge latch, level term.
// Assumes sig is already synchronised to clk and ORed over its pin group.
`include "nipc_defs.vh"

module nipc_ext_sense #(
  parameter HAS_HIGH_LEVEL = 1
) (
  // Clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // Line and control
  input  wire       sig,
  input  wire [1:0] sens,
  input  wire       inv,
  input  wire       clr,
  // Request
  output wire       pending
);

  reg  prev;
  reg  latch;
  reg  det_rise;
  reg  det_fall;
  reg  lvl_mode;
  wire eff_inv;

  // Both-edges code and lines without inversion never invert.
  assign eff_inv = inv && (HAS_HIGH_LEVEL != 0) && (sens != `NIPC_SENS_BOTH); // [R19]

  always @* begin
    det_rise = 1'b0;
    det_fall = 1'b0;
    lvl_mode = 1'b0;
    case (sens)
      `NIPC_SENS_FALL_LOW: begin
        det_rise = eff_inv;
        det_fall = ~eff_inv;
        lvl_mode = 1'b1;
      end
      `NIPC_SENS_RISE: begin
        det_rise = ~eff_inv;
        det_fall = eff_inv;
      end
      `NIPC_SENS_FALL: begin
        det_rise = eff_inv;
        det_fall = ~eff_inv;
      end
      default: begin
        det_rise = 1'b1;
        det_fall = 1'b1;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      prev  <= 1'b0;
      latch <= 1'b0;
    end else begin
      prev <= sig;
      // A new edge in the clearing cycle is kept.
      latch <= (latch & ~clr) | (det_rise & sig & ~prev) | (det_fall & ~sig & prev); // [R14]
    end
  end

  // The level term follows the pin and needs no clearing.
  assign pending = latch | (lvl_mode & (sig == eff_inv)); // [R14]

endmodule

/* nipc_arbiter.v */
// Picks the request to service: highest software level, then lowest vector.
// Assumes requests are already gated by enables and halt wake capability.
`include "nipc_defs.vh"

module nipc_arbiter #(
  parameter NUM_VEC = 14
) (
  // Requests and levels
  input  wire [NUM_VEC-1:0]   req,
  input  wire [2*NUM_VEC-1:0] prio,
  input  wire [1:0]           cur_level,
  // Winner
  output reg                  win_valid,
  output reg  [3:0]           win_index,
  output reg  [1:0]           win_level
);

  integer i;
  reg [1:0] best_rank;
  reg [1:0] rank;
  reg [1:0] cur_rank;

  // Level code to ordinal: 10->0, 01->1, 00->2, 11->3.
  function [1:0] to_rank;
    input [1:0] code;
    begin
      to_rank = {~(code[1] ^ code[0]), code[0]}; // [R23]
    end
  endfunction

  always @* begin
    win_valid = 1'b0;
    win_index = 4'h0;
    win_level = `NIPC_LEVEL_3;
    best_rank = 2'b00;
    rank      = 2'b00;
    cur_rank  = to_rank(cur_level);
    // Scanning from the highest vector downward lets ties go to the lower number.
    for (i = NUM_VEC - 1; i >= 0; i = i - 1) begin
      rank = to_rank(prio[2*i +: 2]);
      if (req[i] && (rank > cur_rank) && (!win_valid || rank >= best_rank)) begin // [R24] [R25]
        win_valid = 1'b1;
        win_index = i[3:0];
        win_level = prio[2*i +: 2];
        best_rank = rank;
      end
    end
  end

endmodule

/* nipc_ctrl.v */
// Nested interrupt priority controller: priority registers, current level,
// arbitration, vector output, halt wake and external line sensitivity.
// Assumes an APB master on clk, a core issuing one-cycle instruction strobes,
// peripheral requests on clk, and asynchronous port pins.
`include "nipc_defs.vh"

// Operation
// [R1] Four 8-bit priority registers reset to ones
// [R2] Upper nibble of prio_set_3 reads ones
// [R3] Pair codes match current level codes
// [R4] Writing level 0 keeps pair unchanged
// [R5] Pair x serves vector FFFA minus 2x
// [R6] Reset and trap set level 3
// [R7] Raised pending running vector is re-entered
// [R8] Instructions load 10 or 11 into level
// [R9] Masked and unmasked branch condition flags
// [R10] Routine instructions change the running level
// [R11] Fixed vector map with unused slots
// [R12] Only listed sources wake from halt
// [R13] SPI may wake halt unexpectedly
// [R14] External edge and level sensitivity modes
// [R15] Software changes sensitivity only at level 3
// [R16] Changed sensitivity clears pending external requests
// [R17] Control register resets zero, low bits zero
// [R18] Bits 7:6 govern ext_c and ext_d
// [R19] Sensitivity encoding and polarity inversion
// [R20] ext_d never inverted
// [R21] Bit 5 inverts ext_c only
// [R22] Bits 4:3 govern ext_a and ext_b
// [R23] Two-bit level encoding and ordering
// [R24] Highest software then hardware priority wins
// [R25] Serviced only when enabled and above level
// [R26] Bit 2 inverts ext_a, level 3 only
// [R27] Gated or reserved writes are ignored
module nipc_ctrl #(
  parameter NUM_VEC = 14
) (
  // Clock and reset
  input  wire               clk,
  input  wire               sys_rst,
  // APB slave
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [7:0]         paddr,
  input  wire [31:0]        pwdata,
  output reg  [31:0]        prdata,
  output reg                pready,
  output reg                pslverr,
  // Core instruction strobes
  input  wire               enable_irq_instr,
  input  wire               disable_irq_instr,
  input  wire               trap_instr,
  input  wire               halt_instr,
  input  wire               wait_for_irq_instr,
  input  wire               pop_cc_instr,
  input  wire               irq_return_instr,
  input  wire [1:0]         restore_level,
  input  wire               irq_ack,
  // Core power state
  input  wire               in_halt,
  input  wire               in_active_halt,
  // Peripheral requests, already ANDed with their enables
  input  wire [NUM_VEC-1:0] periph_req,
  // Port pins
  input  wire [3:0]         port_a,
  input  wire [2:0]         port_f,
  input  wire [7:0]         port_b,
  // Core side outputs
  output reg  [1:0]         current_level,
  output reg                branch_if_masked,
  output reg                branch_if_unmasked,
  output reg                irq_req,
  output reg  [3:0]         irq_index,
  output reg  [15:0]        irq_vector,
  output reg                wake
);

  // Register state.
  reg  [7:0]           prio_set_0;
  reg  [7:0]           prio_set_1;
  reg  [7:0]           prio_set_2;
  reg  [3:0]           prio_set_3;
  reg  [7:0]           ext_irq_control;
  // Pin synchronisers.
  reg  [14:0]          pin_meta;
  reg  [14:0]          pin_sync;
  // Bus decode.
  wire                 bus_access;
  wire                 bus_write;
  reg                  addr_ok;
  reg  [31:0]          next_rdata;
  // Priority pairs as one vector, pair x at bits 2x+1:2x.
  wire [2*NUM_VEC-1:0] prio_flat;
  wire [2*NUM_VEC-1:0] wr_flat;
  wire [2*NUM_VEC-1:0] next_prio_flat;
  // External lines.
  wire [3:0]           ext_pending;
  wire                 ext_ctrl_write;
  wire                 ext_ctrl_change;
  wire [7:0]           ext_ctrl_new;
  wire [3:0]           ext_ack_clr;
  wire                 ext_clr_all;
  // Arbitration.
  wire [NUM_VEC-1:0]   all_req;
  reg  [NUM_VEC-1:0]   elig_req;
  wire                 win_valid;
  wire [3:0]           win_index;
  wire [1:0]           win_level;
  reg  [1:0]           next_level;
  wire [1:0]           served_level;

  assign bus_access = psel & penable;
  assign bus_write  = bus_access & pwrite & pready;

  // Pins are asynchronous: two flops before any logic.
  always @(posedge clk) begin
    if (sys_rst) begin
      pin_meta <= 15'h0000;
      pin_sync <= 15'h0000;
    end else begin
      pin_meta <= {port_b, port_f, port_a};
      pin_sync <= pin_meta;
    end
  end

  // Register reads.
  always @* begin
    addr_ok    = 1'b1;
    next_rdata = 32'h0000_0000;
    case (paddr)
      `NIPC_OFS_PRIO_SET_0: next_rdata[7:0] = prio_set_0;
      `NIPC_OFS_PRIO_SET_1: next_rdata[7:0] = prio_set_1;
      `NIPC_OFS_PRIO_SET_2: next_rdata[7:0] = prio_set_2;
      `NIPC_OFS_PRIO_SET_3: next_rdata[7:0] = {`NIPC_PRIO3_RO_ONES, prio_set_3}; // [R2]
      `NIPC_OFS_EXT_CTRL:   next_rdata[7:0] = ext_irq_control;
      `NIPC_OFS_STATUS:     next_rdata[11:0] = {ext_pending, irq_index, win_valid,
                                                1'b0, current_level};
      default:              addr_ok = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle and drops after.
  always @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (bus_access && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~addr_ok;
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  assign prio_flat = {prio_set_3, prio_set_2, prio_set_1, prio_set_0};
  assign wr_flat   = {pwdata[3:0], pwdata[7:0], pwdata[7:0], pwdata[7:0]};

  // Per-pair write filter: a pair written with level 0 keeps its old value.
  genvar g;
  generate
    for (g = 0; g < NUM_VEC; g = g + 1) begin : pair_wr
      // Up to four pairs share one register word; prio_set_3 holds two.
      localparam [7:0] WORD_ADDR = (g / 4) * 4;
      wire sel;
      wire keep;
      assign sel  = bus_write && (paddr == WORD_ADDR);
      assign keep = (wr_flat[2*g +: 2] == `NIPC_LEVEL_0); // [R4]
      assign next_prio_flat[2*g +: 2] = (sel && !keep) ? wr_flat[2*g +: 2] : // [R3]
                                                         prio_flat[2*g +: 2];
    end
  endgenerate

  always @(posedge clk) begin
    if (sys_rst) begin
      prio_set_0 <= `NIPC_PRIO_RESET; // [R1]
      prio_set_1 <= `NIPC_PRIO_RESET;
      prio_set_2 <= `NIPC_PRIO_RESET;
      prio_set_3 <= `NIPC_PRIO3_RO_ONES;
    end else begin
      prio_set_0 <= next_prio_flat[7:0];
      prio_set_1 <= next_prio_flat[15:8];
      prio_set_2 <= next_prio_flat[23:16];
      prio_set_3 <= next_prio_flat[27:24];
    end
  end

  // Sensitivity and polarity are writable only at level 3.
  assign ext_ctrl_write  = bus_write && (paddr == `NIPC_OFS_EXT_CTRL) &&
                           (current_level == `NIPC_LEVEL_3); // [R15] [R26] [R27]
  assign ext_ctrl_new    = pwdata[7:0] & `NIPC_EXT_CTRL_WMASK; // [R17] [R27]
  assign ext_ctrl_change = ext_ctrl_write && (ext_ctrl_new != ext_irq_control);
  assign ext_clr_all     = ext_ctrl_change; // [R16]

  always @(posedge clk) begin
    if (sys_rst) begin
      ext_irq_control <= `NIPC_EXT_CTRL_RESET; // [R17]
    end else if (ext_ctrl_write) begin
      ext_irq_control <= ext_ctrl_new;
    end
  end

  // Entering a routine clears that line's edge latch.
  generate
    for (g = 0; g < 4; g = g + 1) begin : ext_clr
      localparam [3:0] LINE_IDX = `NIPC_IDX_EXT_A + g;
      assign ext_ack_clr[g] = ext_clr_all |
                              (irq_ack && irq_req && irq_index == LINE_IDX);
    end
  endgenerate

  nipc_ext_sense #(.HAS_HIGH_LEVEL(1)) u_ext_a (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sig     (|pin_sync[3:0]),
    .sens    (ext_irq_control[`NIPC_SENS_PORTAF_HI:`NIPC_SENS_PORTAF_LO]), // [R22]
    .inv     (ext_irq_control[`NIPC_POL_INV_A]), // [R26]
    .clr     (ext_ack_clr[0]),
    .pending (ext_pending[0])
  );

  nipc_ext_sense #(.HAS_HIGH_LEVEL(0)) u_ext_b (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sig     (|pin_sync[6:4]),
    .sens    (ext_irq_control[`NIPC_SENS_PORTAF_HI:`NIPC_SENS_PORTAF_LO]), // [R22]
    .inv     (1'b0),
    .clr     (ext_ack_clr[1]),
    .pending (ext_pending[1])
  );

  nipc_ext_sense #(.HAS_HIGH_LEVEL(1)) u_ext_c (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sig     (|pin_sync[10:7]),
    .sens    (ext_irq_control[`NIPC_SENS_PORTB_HI:`NIPC_SENS_PORTB_LO]), // [R18]
    .inv     (ext_irq_control[`NIPC_POL_INV_B]), // [R21]
    .clr     (ext_ack_clr[2]),
    .pending (ext_pending[2])
  );

  nipc_ext_sense #(.HAS_HIGH_LEVEL(0)) u_ext_d (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sig     (|pin_sync[14:11]),
    .sens    (ext_irq_control[`NIPC_SENS_PORTB_HI:`NIPC_SENS_PORTB_LO]), // [R18]
    .inv     (1'b0), // [R20]
    .clr     (ext_ack_clr[3]),
    .pending (ext_pending[3])
  );

  // External lines replace vectors 2 to 5; unused vectors never request.
  assign all_req = ({periph_req[NUM_VEC-1:6], ext_pending, periph_req[1:0]}) &
                   `NIPC_USED_MASK; // [R11]

  // While halted only wake-capable sources may be served first; the others
  // stay latched and follow once the core runs again.
  always @* begin
    if (in_active_halt) begin
      elig_req = all_req & `NIPC_AHALT_WAKE_MASK; // [R12]
    end else if (in_halt) begin
      elig_req = all_req & `NIPC_HALT_WAKE_MASK; // [R12] [R13]
    end else begin
      elig_req = all_req;
    end
  end

  nipc_arbiter #(.NUM_VEC(NUM_VEC)) u_arb (
    .req       (elig_req),
    .prio      (prio_flat),
    .cur_level (current_level),
    .win_valid (win_valid), // [R7]
    .win_index (win_index),
    .win_level (win_level)
  );

  assign served_level = prio_flat[2*irq_index +: 2];

  // Current level: service has precedence over instruction strobes.
  always @* begin
    if (irq_ack && irq_req) begin
      next_level = served_level; // [R25] [R3]
    end else if (trap_instr || disable_irq_instr) begin
      next_level = `NIPC_LEVEL_3; // [R6] [R8]
    end else if (enable_irq_instr || halt_instr || wait_for_irq_instr) begin
      next_level = `NIPC_LEVEL_0; // [R8] [R10]
    end else if (pop_cc_instr || irq_return_instr) begin
      next_level = restore_level; // [R10]
    end else begin
      next_level = current_level;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      current_level      <= `NIPC_LEVEL_3; // [R6]
      branch_if_masked   <= 1'b1;
      branch_if_unmasked <= 1'b0;
    end else begin
      current_level      <= next_level;
      branch_if_masked   <= (next_level == `NIPC_LEVEL_3); // [R9]
      branch_if_unmasked <= (next_level != `NIPC_LEVEL_3); // [R9]
    end
  end

  // Vector output; reset and trap override the maskable winner.
  always @(posedge clk) begin
    if (sys_rst) begin
      irq_req    <= 1'b0;
      irq_index  <= 4'h0;
      irq_vector <= `NIPC_VEC_RESET; // [R11]
      wake       <= 1'b0;
    end else begin
      irq_req   <= win_valid & ~(irq_ack & irq_req);
      irq_index <= win_index;
      if (trap_instr) begin
        irq_vector <= `NIPC_VEC_TRAP; // [R11]
      end else if (win_valid) begin
        irq_vector <= `NIPC_VEC_PAIR0 - {11'h000, win_index, 1'b0}; // [R5]
      end
      // Trap never wakes the core; only sources in the halt or active-halt wake mask do, SPI among them.
      wake <= (in_halt | in_active_halt) & win_valid; // [R12]
    end
  end

endmodule

/* nipc_core_model.sv */
// Core model that acknowledges interrupt requests, promptly or after a delay.
// Assumes irq_req is a level from the controller on the same clock.
module nipc_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Request and pacing
  input  wire logic       irq_req,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_delay,
  // Acknowledge
  output logic            irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // The acknowledge is a single pulse, and only while the request is still up.
  always @(posedge clk) begin
    if (sys_rst || !irq_req || !ack_en || irq_ack) begin
      irq_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= ack_delay) begin
      irq_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

/* nipc_ctrl_assertions.sv */
// Checker of the interrupt controller ports, bound into every nipc_ctrl.
// Assumes one clock and a synchronous active-high reset.
module nipc_chk (
  // Clock and reset
  input logic        clk,
  input logic        sys_rst,
  // Core side
  input logic        enable_irq_instr,
  input logic        disable_irq_instr,
  input logic        trap_instr,
  input logic        halt_instr,
  input logic        wait_for_irq_instr,
  input logic        pop_cc_instr,
  input logic        irq_return_instr,
  input logic [1:0]  restore_level,
  input logic        irq_ack,
  input logic        in_halt,
  input logic        in_active_halt,
  // Results
  input logic [1:0]  current_level,
  input logic        branch_if_masked,
  input logic        branch_if_unmasked,
  input logic        irq_req,
  input logic [3:0]  irq_index,
  input logic [15:0] irq_vector,
  input logic        wake
);
  timeunit 1ns;
  timeprecision 1ps;
  wire ack_go = irq_ack & irq_req;
  wire top_op = ack_go | trap_instr | disable_irq_instr;
  wire mid_op = enable_irq_instr | halt_instr | wait_for_irq_instr;
  wire any_op = top_op | mid_op | pop_cc_instr | irq_return_instr;
  wire halted = in_halt | in_active_halt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_masked_flag: assert property (branch_if_masked == (current_level == 2'b11))
    else $error("masked flag wrong");
  a_unmasked_flag: assert property (branch_if_unmasked != branch_if_masked)
    else $error("unmasked flag wrong");
  a_enable_level: assert property (mid_op && !top_op |=> current_level == 2'b10)
    else $error("level not 10");
  a_disable_level: assert property (top_op && !ack_go |=> current_level == 2'b11)
    else $error("level not 11");
  a_restore_level: assert property (
    (pop_cc_instr | irq_return_instr) && !top_op && !mid_op
    |=> current_level == $past(restore_level)) else $error("level not restored");
  a_level_hold: assert property (!any_op |=> $stable(current_level))
    else $error("level moved");
  a_reset_vector: assert property ($fell(sys_rst) |-> irq_vector == 16'hfffe)
    else $error("no reset vector");
  a_trap_vector: assert property (trap_instr && !ack_go |=> irq_vector == 16'hfffc)
    else $error("no trap vector");
  a_vector_map: assert property (
    irq_req |-> irq_vector == 16'hfffa - {11'h000, irq_index, 1'b0})
    else $error("vector mismatch");
  a_req_level: assert property (irq_req |-> $past(current_level) != 2'b11)
    else $error("request at level 3");
  a_wake_halted: assert property (wake |-> halted || $past(halted))
    else $error("wake while running");
endmodule

bind nipc_ctrl nipc_chk chk_u (
  .clk(clk), .sys_rst(sys_rst), .enable_irq_instr(enable_irq_instr),
  .disable_irq_instr(disable_irq_instr), .trap_instr(trap_instr), .halt_instr(halt_instr),
  .wait_for_irq_instr(wait_for_irq_instr), .pop_cc_instr(pop_cc_instr),
  .irq_return_instr(irq_return_instr), .restore_level(restore_level), .irq_ack(irq_ack),
  .in_halt(in_halt), .in_active_halt(in_active_halt), .current_level(current_level),
  .branch_if_masked(branch_if_masked), .branch_if_unmasked(branch_if_unmasked),
  .irq_req(irq_req), .irq_index(irq_index), .irq_vector(irq_vector), .wake(wake)
);

/* tb.sv */
// Self-checking bench of the interrupt controller with a core model.
// Assumes the design files and the core model are compiled before it.
`include "nipc_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, port_b = 8'hff, pexp, rnd;
  logic [31:0] pwdata = 32'h0;
  logic [6:0]  strb = 7'h00;
  logic [1:0]  restore_level = 2'b00;
  logic        in_halt = 1'b0, in_active_halt = 1'b0, ack_en = 1'b0;
  logic [3:0]  ack_delay = 4'h0, port_a = 4'h0;
  logic [13:0] periph_req = 14'h0;
  logic [2:0]  port_f = 3'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq_ack, branch_if_masked, branch_if_unmasked, irq_req, wake;
  wire  [1:0]  current_level;
  wire  [3:0]  irq_index;
  wire  [15:0] irq_vector;
  logic [32:0] exp_q[$];
  int          mismatches = 0, n_compared = 0;
  int          wk_src[6] = '{1, 8, 7, 1, 7, 6};
  logic [1:0]  wk_mode[6] = '{2'b10, 2'b10, 2'b01, 2'b01, 2'b10, 2'b10};
  logic [5:0]  wk_exp = 6'b011001;

  nipc_ctrl dut_u (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enable_irq_instr(strb[0]), .disable_irq_instr(strb[1]), .trap_instr(strb[2]),
    .halt_instr(strb[3]), .wait_for_irq_instr(strb[4]), .pop_cc_instr(strb[5]),
    .irq_return_instr(strb[6]), .restore_level(restore_level), .irq_ack(irq_ack),
    .in_halt(in_halt), .in_active_halt(in_active_halt), .periph_req(periph_req),
    .port_a(port_a), .port_f(port_f), .port_b(port_b), .current_level(current_level),
    .branch_if_masked(branch_if_masked), .branch_if_unmasked(branch_if_unmasked),
    .irq_req(irq_req), .irq_index(irq_index), .irq_vector(irq_vector), .wake(wake)
  );
  nipc_core_model core_u (
    .clk(clk), .sys_rst(sys_rst), .irq_req(irq_req), .ack_en(ack_en),
    .ack_delay(ack_delay), .irq_ack(irq_ack)
  );

  initial forever #5 clk = ~clk;

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Reads queue their expectation; the monitor below compares at pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [32:0] e);
    int i;
    if (!w) exp_q.push_back(e);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      mismatches++;
      print_verdict;
    end
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic wait_req(input logic v);
    int i;
    for (i = 0; irq_req !== v && i < 40; i++) @(posedge clk);
    if (i >= 40) begin
      mismatches++;
      print_verdict;
    end
  endtask
  task automatic op(input int k, input logic [1:0] lv);
    strb[k] <= 1'b1;
    @(posedge clk);
    strb <= 7'h00;
    @(posedge clk);
    chk(current_level, lv, "level");
    chk(branch_if_masked, lv == 2'b11, "masked");
  endtask
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw);
    merge = nw;
    for (int k = 0; k < 8; k += 2) if (nw[k+:2] == 2'b10) merge[k+:2] = old[k+:2];
  endfunction

  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front(), "read");

  initial begin
    void'($urandom(32'ha93dd874));
    tick(20);
    sys_rst <= 1'b0;
    for (int k = 0; k < 4; k++) apb(1'b0, 8'(k * 4), 8'h00, 33'h0ff);
    chk(current_level, 2'b11, "reset level");
    chk(irq_vector, 16'hfffe, "reset vector");
    apb(1'b0, 8'h18, 8'h00, 33'h100000000);
    apb(1'b0, `NIPC_OFS_EXT_CTRL, 8'h00, 33'h000);
    apb(1'b1, 8'h00, 8'hcf, 33'h0);
    apb(1'b1, 8'h00, 8'h64, 33'h0);
    apb(1'b0, 8'h00, 8'h00, 33'h044);
    pexp = 8'hff;
    repeat (6) begin
      rnd = 8'($urandom);
      apb(1'b1, 8'h04, rnd, 33'h0);
      pexp = merge(pexp, rnd);
      apb(1'b0, 8'h04, 8'h00, {25'h0, pexp});
    end
    apb(1'b1, 8'h0c, 8'h00, 33'h0);
    apb(1'b0, 8'h0c, 8'h00, 33'h0f0);
    for (int k = 0; k < 4; k++) apb(1'b1, 8'(k * 4), 8'hff, 33'h0);
    apb(1'b1, `NIPC_OFS_EXT_CTRL, 8'hff, 33'h0);
    apb(1'b0, `NIPC_OFS_EXT_CTRL, 8'h00, 33'h0fc);
    op(0, 2'b10);
    apb(1'b1, `NIPC_OFS_EXT_CTRL, 8'h00, 33'h0);
    apb(1'b0, `NIPC_OFS_EXT_CTRL, 8'h00, 33'h0fc);
    op(1, 2'b11);
    op(3, 2'b10);
    op(2, 2'b11);
    chk(irq_vector, 16'hfffc, "trap vector");
    op(4, 2'b10);
    restore_level <= 2'b01;
    op(5, 2'b01);
    restore_level <= 2'b10;
    op(6, 2'b10);
    for (int k = 0; k < 6; k++) begin
      {periph_req, in_halt, in_active_halt} <= {14'(1 << wk_src[k]), wk_mode[k]};
      tick(3);
      chk(wake, wk_exp[k], "wake");
      chk(irq_req, wk_exp[k], "request");
    end
    {periph_req, in_halt, in_active_halt} <= {14'h0082, 2'b00};
    tick(3);
    chk(irq_index, 4'd1, "tie winner");
    chk(irq_vector, 16'hfff8, "vector");
    periph_req <= 14'h0000;
    apb(1'b1, 8'h08, 8'hf1, 33'h0);
    periph_req <= 14'h0300;
    wait_req(1'b1);
    chk(irq_index, 4'd9, "level winner");
    chk(irq_vector, 16'hffe8, "vector");
    ack_en <= 1'b1;
    wait_req(1'b0);
    ack_en <= 1'b0;
    chk(current_level, 2'b00, "serviced level");
    ack_delay <= 4'h5;
    apb(1'b1, 8'h08, 8'hfd, 33'h0);
    wait_req(1'b1);
    chk(irq_index, 4'd9, "reentry");
    ack_en <= 1'b1;
    wait_req(1'b0);
    {ack_en, periph_req} <= 15'h0000;
    chk(current_level, 2'b11, "reentry level");
    op(6, 2'b10);
    op(1, 2'b11);
    apb(1'b1, `NIPC_OFS_EXT_CTRL, 8'h14, 33'h0);
    op(0, 2'b10);
    port_f <= 3'h7;
    tick(8);
    chk(irq_req, 1'b0, "ext_b rise");
    port_a <= 4'h1;
    wait_req(1'b1);
    chk(irq_index, 4'd2, "ext_a");
    op(1, 2'b11);
    apb(1'b1, `NIPC_OFS_EXT_CTRL, 8'h10, 33'h0);
    op(0, 2'b10);
    tick(3);
    chk(irq_req, 1'b0, "cleared");
    // Port B falls at level 3; the following control write must clear it.
    port_b <= 8'h00;
    op(1, 2'b11);
    apb(1'b1, `NIPC_OFS_EXT_CTRL, 8'h70, 33'h0);
    op(0, 2'b10);
    port_b <= 8'hff;
    wait_req(1'b1);
    chk(irq_index, 4'd5, "ext_d");
    ack_en <= 1'b1;
    wait_req(1'b0);
    ack_en <= 1'b0;
    op(6, 2'b10);
    tick(6);
    chk(irq_req, 1'b0, "ext_c");
    print_verdict;
  end
endmodule
